// *** pph_handshake.sv ***
// What this block does
// R01: a rising edge of move_launch starts a move to the selected target.
// R02: host holds target select stable 6 ms before raising move_launch.
// R03: target and done numbers are binary weighted 1..32, bit0 lowest.
// R04: pause_n high allows motion; low makes the actuator decelerate to stop.
// R05: origin_seek_cmd held drives the actuator in the positive direction.
// R06: servo stays energised while servo_enable is high, off while low.
// R07: each rising edge of alarm_clear clears a pending alarm.
// R08: on completion the reached position number goes onto done_position.
// R09: done_position drops to zero when the next move_launch arrives.
// R10: motion_active is high while moving, including load contact detection.
// R11: in_position rises once target reached and inside the in-position band.
// R12: origin_found is low from power-up until homing completes.
// R13: region flags only after homing and while position lies in range.
// R14: servo_ready when servo energised and controller ready to run.
// R15: fault_n high normally, low whenever an alarm is present.
// R16: with cutoff relay fitted, estop_n low during an emergency stop.
// R17: signal assignment follows a pattern setting of 0 to 5.
// R18: pattern 2 gives 64 targets and drops servo, ready and region flags.
// R19: pattern 3 gives two region flags, second from own bounds, no moving.
`timescale 1ns/1ps
`default_nettype none
module pph_handshake
	import pph_pkg::*;
#(
	parameter int SETUP_CYCLES = PPH_SETUP_CYCLES
) (
	input  wire logic                  clk_in,
	input  wire logic                  reset_n_in,
	input  wire pph_plc_in_t           plc_in,
	output pph_plc_out_t               plc_out,
	input  wire pph_core_sts_t         core_sts_in,
	output pph_core_cmd_t              core_cmd_out,
	input  wire logic [PPH_ADDR_W-1:0] reg_addr_in,
	input  wire logic [PPH_DATA_W-1:0] reg_wdata_in,
	input  wire logic                  reg_write_in,
	input  wire logic                  reg_read_in,
	output logic      [PPH_DATA_W-1:0] reg_rdata_out,
	output logic                       irq_out
);

	// ****************************************************************
	// pin synchronisers and edges
	// ****************************************************************
	pph_plc_in_t sync1_reg;
	pph_plc_in_t sync2_reg;
	pph_plc_in_t prev_reg;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= '0;
		end else begin
			sync1_reg <= plc_in;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	logic launch_rise;
	logic clear_rise;
	assign launch_rise = sync2_reg.move_launch & ~prev_reg.move_launch; // [R01]
	assign clear_rise  = sync2_reg.alarm_clear & ~prev_reg.alarm_clear; // [R07]

	// ****************************************************************
	// registers
	// ****************************************************************
	pph_pattern_t         pattern_reg;
	logic                 relay_fitted_reg;
	logic [PPH_POS_W-1:0] region_flag_a_lo_reg;
	logic [PPH_POS_W-1:0] region_flag_a_hi_reg;
	logic [PPH_POS_W-1:0] region_flag_b_lo_reg;
	logic [PPH_POS_W-1:0] region_flag_b_hi_reg;
	logic [PPH_INT_W-1:0] int_mask_reg;
	logic                 wr_pattern;

	assign wr_pattern = reg_write_in && (reg_addr_in == PPH_OFF_PATTERN);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pattern_reg      <= PAT_CONVENTIONAL;
			relay_fitted_reg <= 1'b0;
			region_flag_a_lo_reg     <= PPH_ZONE_LO_RESET;
			region_flag_a_hi_reg     <= PPH_ZONE_HI_RESET;
			region_flag_b_lo_reg     <= PPH_ZONE_LO_RESET;
			region_flag_b_hi_reg     <= PPH_ZONE_HI_RESET;
			int_mask_reg     <= '0;
		end else if (reg_write_in) begin
			// pattern values whose low three bits exceed 5 are ignored
			if (wr_pattern && reg_wdata_in[2:0] <= PAT_AIR4) begin // [R17]
				pattern_reg <= pph_pattern_t'(reg_wdata_in[2:0]);
			end
			if (reg_addr_in == PPH_OFF_CTRL) begin
				relay_fitted_reg <= reg_wdata_in[0];
			end
			if (reg_addr_in == PPH_OFF_REGION_FLAG_A_LO) begin
				region_flag_a_lo_reg <= reg_wdata_in[PPH_POS_W-1:0];
			end
			if (reg_addr_in == PPH_OFF_REGION_FLAG_A_HI) begin
				region_flag_a_hi_reg <= reg_wdata_in[PPH_POS_W-1:0];
			end
			if (reg_addr_in == PPH_OFF_REGION_FLAG_B_LO) begin
				region_flag_b_lo_reg <= reg_wdata_in[PPH_POS_W-1:0];
			end
			if (reg_addr_in == PPH_OFF_REGION_FLAG_B_HI) begin
				region_flag_b_hi_reg <= reg_wdata_in[PPH_POS_W-1:0];
			end
			if (reg_addr_in == PPH_OFF_INT_MASK) begin
				int_mask_reg <= reg_wdata_in[PPH_INT_W-1:0];
			end
		end
	end

	// ****************************************************************
	// pattern features
	// ****************************************************************
	logic has_home;
	logic has_servo;
	logic has_reset;
	logic has_moving;
	logic has_zone_a;
	logic has_zone_b;
	logic has_ready;

	always_comb begin
		has_home   = (pattern_reg != PAT_CONVENTIONAL) &&
			(pattern_reg != PAT_AIR4);
		has_servo  = (pattern_reg == PAT_STANDARD) ||
			(pattern_reg == PAT_TWO_ZONE) || (pattern_reg == PAT_TEACH);
		has_ready  = has_servo; // [R18]
		has_reset  = (pattern_reg != PAT_CONVENTIONAL);
		has_moving = (pattern_reg == PAT_STANDARD) ||
			(pattern_reg == PAT_POINTS64) ||
			(pattern_reg == PAT_TEACH); // [R19]
		has_zone_a = (pattern_reg != PAT_POINTS64) &&
			(pattern_reg != PAT_TEACH); // [R18]
		has_zone_b = (pattern_reg == PAT_TWO_ZONE); // [R19]
	end

	// ****************************************************************
	// alarm, servo, emergency stop
	// ****************************************************************
	logic alarm_reg;
	logic servo_on;
	logic estop_now;

	// without a reset input, an alarm clears only by device reset
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			alarm_reg <= 1'b0;
		end else if (core_sts_in.fault_event) begin
			alarm_reg <= 1'b1;
		end else if (clear_rise && has_reset) begin
			alarm_reg <= 1'b0; // [R07]
		end
	end

	assign servo_on  = has_servo ? sync2_reg.servo_enable : 1'b1; // [R06]
	assign estop_now = relay_fitted_reg && core_sts_in.estop_active; // [R16]

	// ****************************************************************
	// move and homing sequencer
	// ****************************************************************
	pph_state_t           state_reg;
	logic [PPH_NUM_W-1:0] target_reg;
	logic [PPH_NUM_W-1:0] target_now;
	logic                 move_finish;
	logic                 homed_reg;

	// only 64-point mode uses the two upper select bits
	assign target_now = (pattern_reg == PAT_POINTS64) ?
		sync2_reg.target_select :
		(sync2_reg.target_select & PPH_TARGET16_MASK); // [R03] [R18]
	assign move_finish = (state_reg == ST_MOVE) && core_sts_in.move_done;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg  <= ST_IDLE;
			target_reg <= '0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (launch_rise) begin
						state_reg  <= ST_MOVE;
						target_reg <= target_now; // [R01]
					end else if (has_home && sync2_reg.origin_seek_cmd) begin
						state_reg <= ST_HOME;
					end
				end
				ST_MOVE: begin
					if (launch_rise) begin
						target_reg <= target_now; // [R01]
					end else if (core_sts_in.move_done) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_HOME: begin
					if (core_sts_in.homing_done ||
						!sync2_reg.origin_seek_cmd) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			homed_reg <= 1'b0; // [R12]
		end else if (core_sts_in.homing_done) begin
			homed_reg <= 1'b1; // [R12]
		end
	end

	// ****************************************************************
	// target setup time monitor
	// ****************************************************************
	logic [PPH_SETUP_CNT_W-1:0] stable_cnt_reg;
	logic                       setup_short;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stable_cnt_reg <= '0;
		end else if (sync2_reg.target_select != prev_reg.target_select) begin
			stable_cnt_reg <= '0;
		end else if (stable_cnt_reg < PPH_SETUP_CNT_W'(SETUP_CYCLES)) begin
			stable_cnt_reg <= stable_cnt_reg + 1'b1;
		end
	end

	assign setup_short = launch_rise &&
		(stable_cnt_reg < PPH_SETUP_CNT_W'(SETUP_CYCLES)); // [R02]

	// ****************************************************************
	// core commands and pin outputs
	// ****************************************************************
	logic in_zone_a;
	logic in_zone_b;

	assign in_zone_a = (core_sts_in.position >= region_flag_a_lo_reg) &&
		(core_sts_in.position <= region_flag_a_hi_reg);
	assign in_zone_b = (core_sts_in.position >= region_flag_b_lo_reg) &&
		(core_sts_in.position <= region_flag_b_hi_reg);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			core_cmd_out <= '0;
		end else begin
			core_cmd_out.move_request  <= launch_rise; // [R01]
			if (launch_rise) begin
				core_cmd_out.target_number <= target_now;
			end
			core_cmd_out.motion_permit <= sync2_reg.pause_n; // [R04]
			core_cmd_out.seek_positive <= has_home &&
				sync2_reg.origin_seek_cmd; // [R05]
			core_cmd_out.servo_on      <= servo_on; // [R06]
			core_cmd_out.alarm_reset   <= clear_rise && has_reset; // [R07]
		end
	end

	// one process drives every pin field
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			plc_out.done_position <= '0;
			plc_out.in_position   <= 1'b0;
			plc_out.motion_active <= 1'b0;
			plc_out.origin_found  <= 1'b0;
			plc_out.region_flag_a <= 1'b0;
			plc_out.region_flag_b <= 1'b0;
			plc_out.servo_ready   <= 1'b0;
			plc_out.fault_n       <= 1'b1;
			plc_out.estop_n       <= 1'b1;
		end else begin
			if (launch_rise) begin
				plc_out.done_position <= '0; // [R09]
				plc_out.in_position   <= 1'b0;
			end else if (move_finish && core_sts_in.in_band) begin
				plc_out.done_position <= target_reg; // [R08]
				plc_out.in_position   <= 1'b1; // [R11]
			end
			plc_out.motion_active <= has_moving &&
				core_sts_in.moving; // [R10]
			plc_out.origin_found  <= homed_reg; // [R12]
			plc_out.region_flag_a <= has_zone_a && homed_reg &&
				in_zone_a; // [R13]
			plc_out.region_flag_b <= has_zone_b && homed_reg &&
				in_zone_b; // [R13] [R19]
			plc_out.servo_ready   <= has_ready && servo_on &&
				!alarm_reg && !estop_now; // [R14]
			plc_out.fault_n       <= !alarm_reg; // [R15]
			plc_out.estop_n       <= !estop_now; // [R16]
		end
	end

	// ****************************************************************
	// interrupts and read port
	// ****************************************************************
	logic [PPH_INT_W-1:0] int_stat_reg;
	logic [PPH_INT_W-1:0] int_event;
	logic [PPH_INT_W-1:0] int_clear;

	always_comb begin
		int_event = '0;
		int_event[PPH_INT_DONE]  = move_finish;
		int_event[PPH_INT_ALARM] = core_sts_in.fault_event;
		int_event[PPH_INT_HOMED] = core_sts_in.homing_done;
		int_event[PPH_INT_ESTOP] = estop_now;
		int_event[PPH_INT_SETUP] = setup_short;
		int_clear = '0;
		if (reg_write_in && reg_addr_in == PPH_OFF_INT_STAT) begin
			int_clear = reg_wdata_in[PPH_INT_W-1:0];
		end
	end

	// set beats clear in the same cycle
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			int_stat_reg <= '0;
			irq_out      <= 1'b0;
		end else begin
			int_stat_reg <= (int_stat_reg & ~int_clear) | int_event;
			irq_out      <= |(int_stat_reg & int_mask_reg);
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= '0;
		end else if (reg_read_in) begin
			unique case (reg_addr_in)
				PPH_OFF_PATTERN:  reg_rdata_out <= {29'h0, pattern_reg};
				PPH_OFF_CTRL:     reg_rdata_out <= {31'h0, relay_fitted_reg};
				PPH_OFF_REGION_FLAG_A_LO: reg_rdata_out <= {16'h0, region_flag_a_lo_reg};
				PPH_OFF_REGION_FLAG_A_HI: reg_rdata_out <= {16'h0, region_flag_a_hi_reg};
				PPH_OFF_REGION_FLAG_B_LO: reg_rdata_out <= {16'h0, region_flag_b_lo_reg};
				PPH_OFF_REGION_FLAG_B_HI: reg_rdata_out <= {16'h0, region_flag_b_hi_reg};
				PPH_OFF_STATUS:   reg_rdata_out <= {18'h0, state_reg,
					alarm_reg, homed_reg, estop_now, servo_on, target_reg,
					2'h0};
				PPH_OFF_INT_STAT: reg_rdata_out <= {27'h0, int_stat_reg};
				PPH_OFF_INT_MASK: reg_rdata_out <= {27'h0, int_mask_reg};
				default:          reg_rdata_out <= '0;
			endcase
		end else begin
			reg_rdata_out <= '0;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_launch;
		launch_rise;
	endsequence
	sequence s_finish;
		move_finish && core_sts_in.in_band && !launch_rise;
	endsequence

	a_launch_request: assert property ( // [R01]
		s_launch |=> core_cmd_out.move_request &&
			core_cmd_out.target_number == $past(target_now)
	) else $error("launch edge gave no move request");
	a_done_cleared: assert property ( // [R09]
		s_launch |=> plc_out.done_position == '0 && !plc_out.in_position
	) else $error("done position not cleared on launch");
	a_done_loaded: assert property ( // [R08]
		s_finish |=> plc_out.done_position == $past(target_reg) &&
			plc_out.in_position
	) else $error("done position not loaded at completion");
	a_pause_stops: assert property ( // [R04]
		!sync2_reg.pause_n |=> !core_cmd_out.motion_permit
	) else $error("motion permitted while paused");
	a_servo_follows: assert property ( // [R06]
		has_servo && $changed(sync2_reg.servo_enable) |=>
			core_cmd_out.servo_on == $past(sync2_reg.servo_enable)
	) else $error("servo command does not follow enable");
	a_origin_cause: assert property ( // [R12]
		$rose(plc_out.origin_found) |-> $past(core_sts_in.homing_done, 2)
	) else $error("origin found without homing done");
	a_zone_homed: assert property ( // [R13]
		plc_out.region_flag_a || plc_out.region_flag_b |->
			$past(homed_reg)
	) else $error("region flag before homing");
	a_fault_pin: assert property ( // [R15]
		core_sts_in.fault_event |=> alarm_reg ##1 !plc_out.fault_n
	) else $error("alarm not shown on fault pin");
	a_points64_strip: assert property ( // [R18]
		pattern_reg == PAT_POINTS64 ##1 pattern_reg == PAT_POINTS64 |->
			!plc_out.servo_ready && !plc_out.region_flag_a
	) else $error("64 point pattern drives removed pins");
	a_two_zone_b: assert property ( // [R19]
		plc_out.region_flag_b |-> $past(pattern_reg) == PAT_TWO_ZONE
	) else $error("second region flag outside pattern 3");
	a_estop_pin: assert property ( // [R16]
		estop_now |=> !plc_out.estop_n
	) else $error("emergency stop not shown on pin");
	a_motion_shown: assert property ( // [R10]
		has_moving && core_sts_in.moving |=> plc_out.motion_active
	) else $error("motion not shown on pin");
	a_alarm_cleared: assert property ( // [R07]
		clear_rise && has_reset && !core_sts_in.fault_event |=> !alarm_reg
	) else $error("alarm clear edge left alarm pending");
	a_ready_needs_servo: assert property ( // [R14]
		!servo_on |=> !plc_out.servo_ready
	) else $error("ready shown with servo off");
	a_seek_shown: assert property ( // [R05]
		has_home && sync2_reg.origin_seek_cmd |=> core_cmd_out.seek_positive
	) else $error("homing input gave no positive seek");
	a_target_masked: assert property ( // [R18]
		launch_rise && pattern_reg != PAT_POINTS64 |=>
			(core_cmd_out.target_number & ~PPH_TARGET16_MASK) == '0
	) else $error("upper target bits used outside pattern 2");

endmodule
`default_nettype wire

// *** pph_pkg.sv ***
package pph_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int PPH_CLK_PERIOD_NS = 20;
	localparam int PPH_SETUP_TIME_NS = 6000000;
	localparam int PPH_SETUP_CYCLES  =
		(PPH_SETUP_TIME_NS + PPH_CLK_PERIOD_NS - 1) / PPH_CLK_PERIOD_NS;
	localparam int PPH_SETUP_CNT_W   = 20;

	// ****************************************************************
	// widths and register map
	// ****************************************************************
	localparam int PPH_NUM_W  = 6;
	localparam int PPH_POS_W  = 16;
	localparam int PPH_ADDR_W = 8;
	localparam int PPH_DATA_W = 32;

	localparam logic [7:0] PPH_OFF_PATTERN   = 8'h00;
	localparam logic [7:0] PPH_OFF_CTRL      = 8'h04;
	localparam logic [7:0] PPH_OFF_REGION_FLAG_A_LO  = 8'h08;
	localparam logic [7:0] PPH_OFF_REGION_FLAG_A_HI  = 8'h0c;
	localparam logic [7:0] PPH_OFF_REGION_FLAG_B_LO  = 8'h10;
	localparam logic [7:0] PPH_OFF_REGION_FLAG_B_HI  = 8'h14;
	localparam logic [7:0] PPH_OFF_STATUS    = 8'h18;
	localparam logic [7:0] PPH_OFF_INT_STAT  = 8'h1c;
	localparam logic [7:0] PPH_OFF_INT_MASK  = 8'h20;

	localparam logic [15:0] PPH_ZONE_LO_RESET = 16'h0000;
	localparam logic [15:0] PPH_ZONE_HI_RESET = 16'hffff;
	localparam logic [5:0]  PPH_TARGET16_MASK = 6'h0f;

	// interrupt bit positions
	localparam int PPH_INT_W     = 5;
	localparam int PPH_INT_DONE  = 0;
	localparam int PPH_INT_ALARM = 1;
	localparam int PPH_INT_HOMED = 2;
	localparam int PPH_INT_ESTOP = 3;
	localparam int PPH_INT_SETUP = 4;

	typedef enum logic [2:0] {
		PAT_CONVENTIONAL = 3'h0,
		PAT_STANDARD     = 3'h1,
		PAT_POINTS64     = 3'h2,
		PAT_TWO_ZONE     = 3'h3,
		PAT_TEACH        = 3'h4,
		PAT_AIR4         = 3'h5
	} pph_pattern_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_MOVE = 2'h1,
		ST_HOME = 2'h2
	} pph_state_t;

	typedef struct packed {
		logic       move_launch;
		logic [5:0] target_select;
		logic       pause_n;
		logic       origin_seek_cmd;
		logic       servo_enable;
		logic       alarm_clear;
	} pph_plc_in_t;

	typedef struct packed {
		logic [5:0] done_position;
		logic       motion_active;
		logic       in_position;
		logic       origin_found;
		logic       region_flag_a;
		logic       region_flag_b;
		logic       servo_ready;
		logic       fault_n;
		logic       estop_n;
	} pph_plc_out_t;

	typedef struct packed {
		logic       move_request;
		logic [5:0] target_number;
		logic       motion_permit;
		logic       seek_positive;
		logic       servo_on;
		logic       alarm_reset;
	} pph_core_cmd_t;

	typedef struct packed {
		logic        moving;
		logic        in_band;
		logic        move_done;
		logic        homing_done;
		logic        fault_event;
		logic        estop_active;
		logic [15:0] position;
	} pph_core_sts_t;

endpackage

// *** pph_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pph_core_model
	import pph_pkg::*;
(
	input  wire logic          clk_in,
	input  wire logic          reset_n_in,
	input  wire pph_core_cmd_t cmd_in,
	input  wire logic          slow_in,
	input  wire logic          band_in,
	input  wire logic          fault_in,
	input  wire logic          estop_in,
	input  wire logic [15:0]   pos_in,
	output pph_core_sts_t      sts_out
);
	// ************
	// motion core
	// ************
	logic [5:0] cnt_reg;
	logic       moving_reg;
	logic       done_reg;
	logic [3:0] hcnt_reg;
	logic       hdone_reg;
	logic       hpulse_reg;

	// a move runs 8 cycles, or 40 with slow_in; the count halts while motion is held
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_reg    <= 6'h00;
			moving_reg <= 1'b0;
			done_reg   <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (cmd_in.move_request) begin
				cnt_reg    <= slow_in ? 6'h28 : 6'h08;
				moving_reg <= 1'b1;
			end else if (cnt_reg != 6'h00 && cmd_in.motion_permit) begin
				cnt_reg <= cnt_reg - 6'h01;
				if (cnt_reg == 6'h01) begin
					moving_reg <= 1'b0;
					done_reg   <= 1'b1;
				end
			end
		end
	end

	// homing finishes once after eight cycles of positive seek
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hcnt_reg   <= 4'h0;
			hdone_reg  <= 1'b0;
			hpulse_reg <= 1'b0;
		end else begin
			hpulse_reg <= 1'b0;
			if (!cmd_in.seek_positive) begin
				hcnt_reg  <= 4'h0;
				hdone_reg <= 1'b0;
			end else if (!hdone_reg) begin
				hcnt_reg <= hcnt_reg + 4'h1;
				if (hcnt_reg == 4'h7) begin
					hdone_reg  <= 1'b1;
					hpulse_reg <= 1'b1;
				end
			end
		end
	end

	assign sts_out = '{moving_reg, band_in, done_reg, hpulse_reg,
		fault_in, estop_in, pos_in};
endmodule
`default_nettype wire

// *** pio_positioning_handshake_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
	compares++; \
	if ((got) !== (ex)) begin \
		errors++; \
		$display("mismatch %s expected %h seen %h", nm, ex, got); \
	end \
end
module pio_positioning_handshake_bench
	import pph_pkg::*;
;
	logic          clk, reset_n, wr_s, rd_s, irq, rd_seen, dn_seen;
	logic          slow, band, fault, estop;
	pph_plc_in_t   pin;
	pph_plc_out_t  pout;
	pph_core_sts_t sts;
	pph_core_cmd_t cmd;
	logic [7:0]    addr;
	logic [31:0]   wdata, rdata, e_rd;
	logic [15:0]   pos;
	logic [6:0]    e_dn;
	logic [5:0]    t;
	logic [31:0]   rq[$];
	logic [6:0]    dq[$];
	int            errors, compares;

	pph_handshake #(.SETUP_CYCLES(16)) i_dut (.clk_in(clk),
		.reset_n_in(reset_n), .plc_in(pin), .plc_out(pout),
		.core_sts_in(sts), .core_cmd_out(cmd), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
		.reg_rdata_out(rdata), .irq_out(irq));
	pph_core_model i_core (.clk_in(clk), .reset_n_in(reset_n),
		.cmd_in(cmd), .slow_in(slow), .band_in(band), .fault_in(fault),
		.estop_in(estop), .pos_in(pos), .sts_out(sts));

	always #10 clk = ~clk;

	// ************
	// drivers
	// ************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		rq.push_back(ex);
		@(posedge clk);
		rd_s <= 1'b0;
	endtask

	task automatic settle();
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic mv(input logic [5:0] tg, input logic [5:0] num,
		input logic b, input logic mact);
		int k;
		@(posedge clk);
		pin.target_select <= tg;
		band <= b;
		slow <= 1'($urandom);
		repeat (20) @(posedge clk); // target held past setup
		pin.move_launch <= 1'b1;
		settle();
		`CHK("done_position", 6'h00, pout.done_position)
		`CHK("in_position", 1'b0, pout.in_position)
		`CHK("motion_active", mact, pout.motion_active)
		dq.push_back({b ? num : 6'h00, b});
		@(posedge clk);
		pin.move_launch <= 1'b0;
		for (k = 0; k < 100 && !sts.move_done; k++) @(negedge clk);
		if (k == 100) `CHK("move end", 1'b1, 1'b0)
		repeat (3) @(posedge clk);
	endtask

	task automatic tally_and_finish();
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ************
	// monitor
	// ************
	always @(posedge clk) begin
		rd_seen <= rd_s;
		dn_seen <= sts.move_done;
	end

	always @(negedge clk) begin
		if (rd_seen) begin
			e_rd = rq.pop_front();
			`CHK("read data", e_rd, rdata)
		end
		if (dn_seen) begin
			e_dn = dq.pop_front();
			`CHK("done pins", e_dn, {pout.done_position, pout.in_position})
		end
	end

	initial begin
		#200000;
		errors++;
		tally_and_finish();
	end

	// ************
	// tests
	// ************
	initial begin
		clk = 1'b0; reset_n = 1'b0; pin = '0; pin.pause_n = 1'b1;
		addr = 8'h00; wdata = 32'h0; wr_s = 1'b0; rd_s = 1'b0;
		slow = 1'b0; band = 1'b0; fault = 1'b0; estop = 1'b0;
		pos = 16'h0000; rd_seen = 1'b0; dn_seen = 1'b0;
		errors = 0; compares = 0;
		void'($urandom(32'ha8be));
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(negedge clk);
		`CHK("fault_n", 1'b1, pout.fault_n)
		`CHK("estop_n", 1'b1, pout.estop_n)
		`CHK("origin_found", 1'b0, pout.origin_found)
		rd(PPH_OFF_PATTERN, 32'h0);
		rd(8'h40, 32'h0);
		rd(PPH_OFF_REGION_FLAG_A_HI, 32'h0000ffff);
		for (int p = 0; p < 7; p++) begin
			wr(PPH_OFF_PATTERN, 32'(p));
			rd(PPH_OFF_PATTERN, (p > 5) ? 32'h5 : 32'(p));
		end
		wr(PPH_OFF_PATTERN, 32'h1);
		@(posedge clk) pin.servo_enable <= 1'b1;
		settle();
		`CHK("servo_on", 1'b1, cmd.servo_on)
		`CHK("servo_ready", 1'b1, pout.servo_ready)
		@(posedge clk) pin.servo_enable <= 1'b0;
		settle();
		`CHK("servo_on", 1'b0, cmd.servo_on)
		`CHK("servo_ready", 1'b0, pout.servo_ready)
		@(posedge clk) pin.pause_n <= 1'b0;
		settle();
		`CHK("motion_permit", 1'b0, cmd.motion_permit)
		@(posedge clk) pin.pause_n <= 1'b1;
		pin.servo_enable <= 1'b1;
		settle();
		`CHK("motion_permit", 1'b1, cmd.motion_permit)
		for (int i = 0; i < 4; i++) begin
			t = 6'($urandom);
			mv(t, t & PPH_TARGET16_MASK, 1'($urandom), 1'b1);
		end
		wr(PPH_OFF_PATTERN, 32'h2);
		mv(6'h2b, 6'h2b, 1'b1, 1'b1);
		`CHK("servo_ready", 1'b0, pout.servo_ready)
		wr(PPH_OFF_PATTERN, 32'h0);
		mv(6'h3a, 6'h0a, 1'b1, 1'b0);
		wr(PPH_OFF_PATTERN, 32'h1);
		wr(PPH_OFF_REGION_FLAG_A_LO, 32'h0064);
		wr(PPH_OFF_REGION_FLAG_A_HI, 32'h00c8);
		@(posedge clk) pos <= 16'h0096;
		settle();
		`CHK("region_flag_a", 1'b0, pout.region_flag_a)
		@(posedge clk) pin.origin_seek_cmd <= 1'b1;
		settle();
		`CHK("seek_positive", 1'b1, cmd.seek_positive)
		`CHK("origin_found", 1'b0, pout.origin_found)
		repeat (12) @(posedge clk);
		@(negedge clk);
		`CHK("origin_found", 1'b1, pout.origin_found)
		`CHK("region_flag_a", 1'b1, pout.region_flag_a)
		@(posedge clk) pin.origin_seek_cmd <= 1'b0;
		pos <= 16'h012c;
		settle();
		`CHK("region_flag_a", 1'b0, pout.region_flag_a)
		wr(PPH_OFF_PATTERN, 32'h3);
		wr(PPH_OFF_REGION_FLAG_B_LO, 32'h00fa);
		wr(PPH_OFF_REGION_FLAG_B_HI, 32'h015e);
		settle();
		`CHK("region_flag_b", 1'b1, pout.region_flag_b)
		mv(6'h07, 6'h07, 1'b1, 1'b0);
		wr(PPH_OFF_PATTERN, 32'h1);
		wr(PPH_OFF_INT_MASK, 32'h0);
		wr(PPH_OFF_INT_STAT, 32'h1f);
		@(posedge clk) fault <= 1'b1;
		@(posedge clk) fault <= 1'b0;
		settle();
		`CHK("fault_n", 1'b0, pout.fault_n)
		`CHK("irq masked", 1'b0, irq)
		rd(PPH_OFF_INT_STAT, 32'h2);
		wr(PPH_OFF_INT_MASK, 32'h2);
		settle();
		`CHK("irq", 1'b1, irq)
		@(posedge clk) pin.alarm_clear <= 1'b1;
		settle();
		`CHK("fault_n", 1'b1, pout.fault_n)
		@(posedge clk) pin.alarm_clear <= 1'b0;
		wr(PPH_OFF_INT_STAT, 32'h2);
		settle();
		`CHK("irq cleared", 1'b0, irq)
		rd(PPH_OFF_INT_STAT, 32'h0);
		wr(PPH_OFF_CTRL, 32'h1);
		@(posedge clk) estop <= 1'b1;
		settle();
		`CHK("estop_n", 1'b0, pout.estop_n)
		wr(PPH_OFF_CTRL, 32'h0);
		settle();
		`CHK("estop_n", 1'b1, pout.estop_n)
		@(posedge clk) estop <= 1'b0;
		repeat (3) @(posedge clk);
		tally_and_finish();
	end
endmodule
`default_nettype wire
